// ==== pkg/hpc_map.svh ====
// Purpose: Register offsets, field positions, reset values and timing of the hot plug control block
// Assumes: Two register maps, one for pin control and one for hot plug policy
// Notes:   Included by its bare name
`ifndef HPC_MAP_SVH
`define HPC_MAP_SVH

// ==========================================================
// Map selection
`define HPC_MAP_PIN              1'b0
`define HPC_MAP_POLICY           1'b1

// ==========================================================
// Offsets
`define HPC_OFS_PIN_CTRL         8'h20
`define HPC_OFS_PIN_STATUS       8'h21
`define HPC_OFS_POLICY           8'h6C

// ==========================================================
// Field positions
`define HPC_BIT_MANUAL_LEVEL     7
`define HPC_BIT_PIN_FLOAT        3
`define HPC_BIT_DRIVE_STATUS     3
`define HPC_BIT_MANUAL_ENABLE    0
`define HPC_LSB_AUTO_POLICY      1
`define HPC_MSB_AUTO_POLICY      2
`define HPC_BIT_TERM_FOLLOW      3
`define HPC_LSB_DELAY_STEP       4
`define HPC_MSB_DELAY_STEP       7

// ==========================================================
// Reset values
`define HPC_RST_MANUAL_LEVEL     1'b1
`define HPC_RST_PIN_FLOAT        1'b0
`define HPC_RST_DRIVE_STATUS     1'b0
`define HPC_RST_MANUAL_ENABLE    1'b0
`define HPC_RST_AUTO_POLICY      2'h1
`define HPC_RST_TERM_FOLLOW      1'b0
`define HPC_RST_DELAY_STEP       4'hA

// ==========================================================
// Timing
`define HPC_CLK_HZ               40000000
`define HPC_STEP_MS              100
`define HPC_STEP_CYCLES          (`HPC_STEP_MS * (`HPC_CLK_HZ / 1000))

`endif

// ==== pkg/hpc_pkg.sv ====
// Purpose: Types of the hot plug control block
// Assumes: Constants live in hpc_map.svh
// Notes:   State is one packed struct
`default_nettype none
package hpc_pkg;

   typedef enum logic [1:0] {
      HPC_POL_IDENT,
      HPC_POL_CABLE,
      HPC_POL_IDENT_CABLE,
      HPC_POL_IDENT_CABLE_MAN
   } hpc_policy_e;

   typedef struct packed {
      logic        manual_level;
      logic        pin_float;
      logic        manual_enable;
      hpc_policy_e policy;
      logic        term_follow;
      logic [3:0]  delay_step;
      logic [21:0] tick_cnt;
      logic [3:0]  step_cnt;
      logic        cable_delayed;
      logic        drive_status;
      logic [7:0]  rdata;
   } hpc_state_s;

endpackage
`default_nettype wire

// ==== hw/hpc_hotplug_ctrl.sv ====
// Purpose: Hot plug assert control of a single receiver port
// Assumes: All inputs synchronous to sys_clk; register port writes one byte per cycle
// Notes:   Pin is open drain: only pulled low, released otherwise
//
// Behaviour
// [R01] Manual enable set: pin follows manual level, policy ignored.
// [R02] Manual level 0 pulls low, 1 requests high; resets to 1.
// [R03] Open-drain pin: only pull low, release for high level.
// [R04] Policy 00: assert with identification memory enable, drop when removed.
// [R05] Policy 01 default: assert after delay from cable presence, drop on loss.
// [R06] Policy 10: assert while memory enabled and delayed presence high.
// [R07] Policy 11: memory enabled, delayed presence and manual level 1 all needed.
// [R08] Four-bit delay in 100 ms steps, 0 none, 15 gives 1.5 s, reset 1 s.
// [R09] Float bit 1 puts pin in high impedance; 0 default normal.
// [R10] Read-only status is 1 while device asserts high level, reset 0.
// [R11] Termination follow bit makes termination track hot plug state.
// [R12] Assertion uses delayed presence; raw presence loss deasserts at once.
// [R13] Raw presence is 1 with high level on cable power pin.
// [R14] Delay counting restarts from zero whenever presence drops early.
`timescale 1ns/1ps
`default_nettype none
`include "hpc_map.svh"

module hpc_hotplug_ctrl
   import hpc_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `HPC_STEP_CYCLES
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       reg_map_sel,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       cable_power_pin,
   input  wire logic       ident_memory_enable,
   input  wire logic       term_normal_enable,
   output logic            term_enable,
   input  wire logic       hotplug_pin_i,
   output logic            hotplug_pin_o,
   output logic            hotplug_pin_oe,
   output logic            hotplug_drive_status
);

   localparam logic [21:0] STEP_LAST = 22'(STEP_CYCLES - 1);

   hpc_state_s state_q;
   hpc_state_s state_d;
   logic       cable_present_raw;
   logic       hotplug_level;

   // ==========================================================
   // Register decode
   function automatic logic hit(input logic map_sel, input logic [7:0] addr,
                                input logic want_map, input logic [7:0] want_addr);
      hit = (map_sel == want_map) && (addr == want_addr);
   endfunction

   assign cable_present_raw = cable_power_pin; // [R13]

   // ==========================================================
   // Hot plug level selection
   always_comb begin
      if (state_q.manual_enable) begin
         hotplug_level = state_q.manual_level; // [R01] [R02]
      end else begin
         case (state_q.policy)
            HPC_POL_IDENT:           hotplug_level = ident_memory_enable; // [R04]
            HPC_POL_CABLE:           hotplug_level = state_q.cable_delayed & cable_present_raw; // [R05] [R12]
            HPC_POL_IDENT_CABLE:     hotplug_level = ident_memory_enable & state_q.cable_delayed
                                                     & cable_present_raw; // [R06]
            HPC_POL_IDENT_CABLE_MAN: hotplug_level = ident_memory_enable & state_q.cable_delayed
                                                     & cable_present_raw & state_q.manual_level; // [R07]
            default:                 hotplug_level = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      state_d = state_q;

      // Register writes
      if (reg_wr) begin
         if (hit(reg_map_sel, reg_addr, `HPC_MAP_PIN, `HPC_OFS_PIN_CTRL)) begin
            state_d.manual_level = reg_wdata[`HPC_BIT_MANUAL_LEVEL];
            state_d.pin_float    = reg_wdata[`HPC_BIT_PIN_FLOAT];
         end
         if (hit(reg_map_sel, reg_addr, `HPC_MAP_POLICY, `HPC_OFS_POLICY)) begin
            state_d.manual_enable = reg_wdata[`HPC_BIT_MANUAL_ENABLE];
            state_d.policy        = hpc_policy_e'(reg_wdata[`HPC_MSB_AUTO_POLICY:`HPC_LSB_AUTO_POLICY]);
            state_d.term_follow   = reg_wdata[`HPC_BIT_TERM_FOLLOW];
            state_d.delay_step    = reg_wdata[`HPC_MSB_DELAY_STEP:`HPC_LSB_DELAY_STEP];
         end
      end

      // Delayed cable presence: 100 ms ticks counted up to the delay field
      if (!cable_present_raw) begin
         state_d.tick_cnt      = '0; // [R14]
         state_d.step_cnt      = '0; // [R14]
         state_d.cable_delayed = 1'b0; // [R12]
      end else if (!state_q.cable_delayed) begin
         if (state_q.step_cnt >= state_q.delay_step) begin
            state_d.cable_delayed = 1'b1; // [R08]
         end else if (state_q.tick_cnt == STEP_LAST) begin
            state_d.tick_cnt = '0;
            state_d.step_cnt = state_q.step_cnt + 4'h1; // [R08]
         end else begin
            state_d.tick_cnt = state_q.tick_cnt + 22'h1;
         end
      end

      state_d.drive_status = hotplug_level & ~state_q.pin_float; // [R10]

      // Read data, unmapped addresses read zero
      state_d.rdata = 8'h00;
      if (reg_rd) begin
         if (hit(reg_map_sel, reg_addr, `HPC_MAP_PIN, `HPC_OFS_PIN_CTRL)) begin
            state_d.rdata[`HPC_BIT_MANUAL_LEVEL] = state_q.manual_level;
            state_d.rdata[`HPC_BIT_PIN_FLOAT]    = state_q.pin_float;
         end
         if (hit(reg_map_sel, reg_addr, `HPC_MAP_PIN, `HPC_OFS_PIN_STATUS)) begin
            state_d.rdata[`HPC_BIT_DRIVE_STATUS] = state_q.drive_status; // [R10]
         end
         if (hit(reg_map_sel, reg_addr, `HPC_MAP_POLICY, `HPC_OFS_POLICY)) begin
            state_d.rdata[`HPC_BIT_MANUAL_ENABLE]                      = state_q.manual_enable;
            state_d.rdata[`HPC_MSB_AUTO_POLICY:`HPC_LSB_AUTO_POLICY]   = state_q.policy;
            state_d.rdata[`HPC_BIT_TERM_FOLLOW]                        = state_q.term_follow;
            state_d.rdata[`HPC_MSB_DELAY_STEP:`HPC_LSB_DELAY_STEP]     = state_q.delay_step;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q.manual_level  <= `HPC_RST_MANUAL_LEVEL; // [R02]
         state_q.pin_float     <= `HPC_RST_PIN_FLOAT; // [R09]
         state_q.manual_enable <= `HPC_RST_MANUAL_ENABLE;
         state_q.policy        <= hpc_policy_e'(`HPC_RST_AUTO_POLICY); // [R05]
         state_q.term_follow   <= `HPC_RST_TERM_FOLLOW;
         state_q.delay_step    <= `HPC_RST_DELAY_STEP; // [R08]
         state_q.tick_cnt      <= '0;
         state_q.step_cnt      <= '0;
         state_q.cable_delayed <= 1'b0;
         state_q.drive_status  <= `HPC_RST_DRIVE_STATUS; // [R10]
         state_q.rdata         <= 8'h00;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // Outputs
   assign hotplug_pin_o        = 1'b0; // [R03]
   // Unless floating, pulled low until the registered status says high, so pin and status move together
   assign hotplug_pin_oe       = ~state_q.pin_float & ~state_q.drive_status; // [R03] [R09]
   assign hotplug_drive_status = state_q.drive_status;
   assign term_enable          = state_q.term_follow ? state_q.drive_status : term_normal_enable; // [R11]
   assign reg_rdata            = state_q.rdata;

endmodule

`default_nettype wire

// ==== tb/hpc_hotplug_ctrl_sva.sv ====
// Purpose: Port checker of the hot plug control
// Assumes: Shadows copy register writes on the design's edge
// Notes:   Bound to the design below
`timescale 1ns/1ps
`default_nettype none
module hpc_hotplug_chk #(parameter int unsigned STEP_CYCLES = 4) (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       reg_map_sel,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cable_power_pin,
   input wire logic       ident_memory_enable,
   input wire logic       hotplug_pin_oe,
   input wire logic       hotplug_drive_status
);
   logic [7:0] pin_q, pol_q, hi_q;
   logic       live, dly;
   int         need;
   assign live = !pol_q[0] && !pin_q[3];
   assign dly  = live && pol_q[2:1] == 2'h1;
   assign need = int'(pol_q[7:4]) * int'(STEP_CYCLES);
   // hi_q counts edges of unbroken cable presence
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_q <= 8'h80;
         pol_q <= 8'hA2;
         hi_q  <= 8'h00;
      end else begin
         if (reg_wr && !reg_map_sel && reg_addr == 8'h20) pin_q <= reg_wdata;
         if (reg_wr && reg_map_sel && reg_addr == 8'h6C) pol_q <= reg_wdata;
         hi_q <= cable_power_pin ? hi_q + {7'h00, ~&hi_q} : 8'h00;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_status_rd; reg_rd && !reg_map_sel && reg_addr == 8'h21; endsequence
   property p_oe; !pin_q[3] |-> hotplug_pin_oe == !hotplug_drive_status; endproperty
   a_oe: assert property (p_oe) else $error("pin drive disagrees with status");
   property p_float; pin_q[3] |-> !hotplug_pin_oe ##1 !hotplug_drive_status; endproperty
   a_float: assert property (p_float) else $error("floating pin still driven");
   property p_manual; pol_q[0] && !pin_q[3] |=> hotplug_drive_status == $past(pin_q[7]); endproperty
   a_manual: assert property (p_manual) else $error("manual level not followed");
   property p_ident; live && pol_q[2:1] == 2'h0 |=> hotplug_drive_status == $past(ident_memory_enable); endproperty
   a_ident: assert property (p_ident) else $error("memory enable not followed");
   property p_loss; live && pol_q[2:1] != 2'h0 && !cable_power_pin |=> !hotplug_drive_status; endproperty
   a_loss: assert property (p_loss) else $error("no drop on cable loss");
   property p_dly_lo; dly && cable_power_pin && hotplug_drive_status |-> int'(hi_q) > need; endproperty
   a_dly_lo: assert property (p_dly_lo) else $error("asserted before delay");
   property p_dly_hi; dly && int'(hi_q) == need + 3 |-> hotplug_drive_status; endproperty
   a_dly_hi: assert property (p_dly_hi) else $error("not asserted after delay");
   property p_rd; s_status_rd |=> reg_rdata == {4'h0, $past(hotplug_drive_status), 3'h0}; endproperty
   a_rd: assert property (p_rd) else $error("status readback wrong");
endmodule
bind hpc_hotplug_ctrl hpc_hotplug_chk #(.STEP_CYCLES(STEP_CYCLES)) u_hpc_hotplug_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_map_sel(reg_map_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cable_power_pin(cable_power_pin),
   .ident_memory_enable(ident_memory_enable), .hotplug_pin_oe(hotplug_pin_oe),
   .hotplug_drive_status(hotplug_drive_status));
`default_nettype wire

// ==== tb/hpc_source_model.sv ====
// Purpose: Video source on the display cable
// Assumes: Bench commands the plug state
// Notes:   Pin high level comes from the pull-up only
`timescale 1ns/1ps
`default_nettype none
module hpc_source_model (
   input  wire logic plug,
   input  wire logic hotplug_pin_o,
   input  wire logic hotplug_pin_oe,
   output logic      cable_power_pin,
   output logic      hotplug_pin_i
);
   assign cable_power_pin = plug;
   assign hotplug_pin_i   = hotplug_pin_oe ? hotplug_pin_o : 1'b1;
endmodule
`default_nettype wire

// ==== tb/hpc_hotplug_ctrl_bench.sv ====
// Purpose: Register-level tests of the hot plug control
// Assumes: Delay step shortened to 4 clocks
// Notes:   Source model drives cable power and the pull-up
`timescale 1ns/1ps
`default_nettype none
module hpc_hotplug_ctrl_bench;
   logic       sys_clk = 1'b0, rst_n = 1'b0, sel = 1'b0, wr = 1'b0, rd = 1'b0;
   logic       ident = 1'b0, tnorm = 1'b1, plug = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic       cable, pin_i, pin_o, pin_oe, term, status;
   int         fails = 0, num_checks = 0, cycles = 0;
   logic [7:0] pols [3] = '{8'h00, 8'h04, 8'h06};
   hpc_hotplug_ctrl #(.STEP_CYCLES(4)) u_hpc_hotplug_ctrl (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_map_sel(sel), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata(rdata), .cable_power_pin(cable), .ident_memory_enable(ident),
      .term_normal_enable(tnorm), .term_enable(term), .hotplug_pin_i(pin_i), .hotplug_pin_o(pin_o),
      .hotplug_pin_oe(pin_oe), .hotplug_drive_status(status));
   hpc_source_model u_hpc_source_model (.plug(plug), .hotplug_pin_o(pin_o), .hotplug_pin_oe(pin_oe),
      .cable_power_pin(cable), .hotplug_pin_i(pin_i));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
      sel <= s;
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge sys_clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      if (!w) chk("reg_rdata", d, rdata);
      @(posedge sys_clk);
   endtask
   task automatic look(input logic st, input logic lvl, input logic tm);
      #1;
      chk("status", {7'h00, st}, {7'h00, status});
      chk("pin", {7'h00, lvl}, {7'h00, pin_i});
      chk("term", {7'h00, tm}, {7'h00, term});
      @(posedge sys_clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      acc(1'b0, 1'b0, 8'h20, 8'h80);
      acc(1'b0, 1'b0, 8'h21, 8'h00);
      acc(1'b0, 1'b1, 8'h6C, 8'hA2);
      acc(1'b0, 1'b0, 8'h22, 8'h00);
      $display("test reset values done");
      acc(1'b1, 1'b1, 8'h6C, 8'h1A);
      look(1'b0, 1'b0, 1'b0);
      plug <= 1'b1;
      repeat (3) @(posedge sys_clk);
      plug <= 1'b0;
      repeat (2) @(posedge sys_clk);
      plug <= 1'b1;
      repeat (4) @(posedge sys_clk);
      look(1'b0, 1'b0, 1'b0);
      repeat (4) @(posedge sys_clk);
      look(1'b1, 1'b1, 1'b1);
      plug <= 1'b0;
      repeat (2) @(posedge sys_clk);
      look(1'b0, 1'b0, 1'b0);
      $display("test delayed presence done");
      for (int i = 0; i < 3; i++) begin
         acc(1'b1, 1'b1, 8'h6C, pols[i]);
         acc(1'b1, 1'b0, 8'h20, 8'h00);
         ident <= 1'b1;
         plug <= 1'b1;
         repeat (4) @(posedge sys_clk);
         look(i < 2, i < 2, 1'b1);
         acc(1'b1, 1'b0, 8'h20, 8'h80);
         look(1'b1, 1'b1, 1'b1);
         ident <= 1'b0;
         repeat (2) @(posedge sys_clk);
         look(1'b0, 1'b0, 1'b1);
      end
      $display("test policies done");
      ident <= 1'b1;
      acc(1'b1, 1'b1, 8'h6C, 8'h01);
      acc(1'b1, 1'b0, 8'h20, 8'h00);
      look(1'b0, 1'b0, 1'b1);
      acc(1'b1, 1'b0, 8'h20, 8'h88);
      look(1'b0, 1'b1, 1'b1);
      acc(1'b0, 1'b0, 8'h21, 8'h00);
      acc(1'b1, 1'b0, 8'h20, 8'h80);
      acc(1'b0, 1'b0, 8'h21, 8'h08);
      tnorm <= 1'b0;
      @(posedge sys_clk);
      look(1'b1, 1'b1, 1'b0);
      acc(1'b0, 1'b1, 8'h6C, 8'h01);
      $display("test manual control done");
      wrap_up();
   end
endmodule
`default_nettype wire
